// *** odcd_cfg.svh ***
// offsets, reset values and field positions of the display command decoder
`ifndef ODCD_CFG_SVH
`define ODCD_CFG_SVH

`define ODCD_OFF_CMD     8'h00
`define ODCD_OFF_DATA    8'h04
`define ODCD_OFF_PTR     8'h08
`define ODCD_OFF_WIN     8'h0C
`define ODCD_OFF_CFG0    8'h10
`define ODCD_OFF_CFG1    8'h14
`define ODCD_OFF_CFG2    8'h18
`define ODCD_OFF_GRAY    8'h1C

`define ODCD_COL_MAX     7'h4F
`define ODCD_ROW_MAX     8'h9F
`define ODCD_MUX_MIN     8'h0F
`define ODCD_RST_MUX     8'h9F
`define ODCD_RST_CONTR   8'h7F
`define ODCD_RST_PRECH   5'h1E
`define ODCD_RST_DIV     4'h1
`define ODCD_RST_OSC     4'h4
`define ODCD_RST_PH1     4'h2
`define ODCD_RST_PH2     4'h7
`define ODCD_GRAY_STEP   7'h04
`define ODCD_LEVEL_TOP   4'hF
`define ODCD_LOCK_BIT    2
`define ODCD_ODDEVEN_BIT 4
`define ODCD_HWREMAP_BIT 5
`define ODCD_SWAP_BIT    6

`endif

// *** odcd_pkg.sv ***
// types shared by the display command decoder
package odcd_pkg;

	typedef enum logic [0:0] {
		ODCD_IDLE  = 1'b0,
		ODCD_PARAM = 1'b1
	} odcd_state_t;

	typedef struct packed {
		logic       vertMode;
		logic       portrait;
		logic       segRemap;
		logic       allOn;
		logic       inverse;
		logic       displayOn;
		logic       scanRev;
		logic       locked;
		logic       segOddEven;
		logic       segHwRemap;
		logic       segSwap;
		logic [7:0] contrast;
		logic [7:0] startLine;
		logic [7:0] offset;
		logic [7:0] muxRatio;
		logic [4:0] precharge;
		logic [3:0] divide;
		logic [3:0] oscFreq;
		logic [3:0] phase1;
		logic [3:0] phase2;
	} odcd_cfg_t;

	typedef struct packed {
		logic       we;
		logic       portrait;
		logic [6:0] col;
		logic [7:0] row;
		logic [7:0] data;
	} odcd_ram_t;

endpackage

// *** odcd_top.sv ***
// display command decoder: apb slave, command parser, pointers, settings
//
// Behaviour
// - horizontal or vertical mode from bit 0
// - column window latched, pointer at start
// - horizontal: column steps, wraps, row advances
// - row window latched, pointer at start
// - vertical: row steps, wraps to start
// - portrait flag independent of increment mode
// - contrast byte stored, higher means brighter
// - segment remap affects later writes only
// - start line 0..159 stored
// - all-on forces brightest level, resume cancels
// - inverse shows 15 minus level
// - multiplex ratio 16..160, default 160
// - display off blanks panel, on enables
// - precharge level stored
// - host sends widths 1..15, level 0 none
// - linear table loads width 4n
// - scan direction takes effect at once
// - display offset stored
// - divider low nibble, oscillator high nibble
// - phase1 low nibble, phase2 high nibble
// - three segment pin selections, default odd/even
// - locked: only lock command accepted
// - columns 0..79, full window at reset
// - rows 0..159, full window at reset
// - lock bit 2, reset unlocked
`timescale 1ns/1ps
`include "odcd_cfg.svh"

module odcd_top
	import odcd_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic [3:0]  pixRaw,
	output logic [3:0]       pixShown,
	output odcd_cfg_t        dispCfg,
	output odcd_ram_t        ramWr
);

	// paramter count of each command code, zero for single byte ones
	function automatic logic [3:0] paramCount(input logic [7:0] c);
		unique case (c)
			8'h21, 8'h22: paramCount = 4'h2;
			8'hBE:        paramCount = 4'hF;
			8'h20, 8'h25, 8'h81, 8'hA2, 8'hA8, 8'hAD, 8'hBC,
			8'hD3, 8'hD5, 8'hD9, 8'hDA, 8'hDB, 8'hFD:
				paramCount = 4'h1;
			default:      paramCount = 4'h0;
		endcase
	endfunction

	// what the panel shows for one stored level
	function automatic logic [3:0] showLevel(input odcd_cfg_t c,
		input logic [3:0] lv);
		if (!c.displayOn)
			showLevel = 4'h0;
		else if (c.allOn)
			showLevel = `ODCD_LEVEL_TOP;
		else if (c.inverse)
			showLevel = `ODCD_LEVEL_TOP - lv;
		else
			showLevel = lv;
	endfunction

	logic        rstMeta_q;
	logic        rstSync_q;
	logic        rst_n;
	logic        pready_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic        setup;
	logic        acc;
	logic        wrCmd;
	logic        wrData;
	logic        mapped;
	odcd_state_t state_q;
	logic [7:0]  cmd_q;
	logic [3:0]  cnt_q;
	logic [7:0]  pbuf_q [0:14];
	logic [3:0]  need;
	logic [7:0]  inByte;
	logic        take;
	logic        fire;
	logic [7:0]  fCmd;
	logic [7:0]  arg1;
	logic [7:0]  arg2;
	odcd_cfg_t   cfg_q;
	logic [6:0]  gray_q [0:15];
	logic [3:0]  graySel_q;
	logic [6:0]  colStart_q;
	logic [6:0]  colEnd_q;
	logic [7:0]  rowStart_q;
	logic [7:0]  rowEnd_q;
	logic [6:0]  col_q;
	logic [7:0]  row_q;
	odcd_ram_t   ramWr_q;
	logic [3:0]  pix_q;

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end
	assign rst_n = rstSync_q;

	// apb phases; one wait state gives a registered answer
	assign setup  = psel & penable & ~pready_q;
	assign acc    = psel & penable & pready_q;
	assign wrCmd  = acc & pwrite & (paddr == `ODCD_OFF_CMD);
	assign wrData = acc & pwrite & (paddr == `ODCD_OFF_DATA);
	assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `ODCD_OFF_GRAY);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			pready_q <= 1'b0;
		else
			pready_q <= setup;
	end

	// read mux and error, loaded in the wait cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			pslverr_q <= ~mapped;
			prdata_q  <= 32'h0000_0000;
			if (!pwrite) begin
				unique case (paddr)
					`ODCD_OFF_PTR:
						prdata_q <= {16'h0000, row_q, 1'b0, col_q};
					`ODCD_OFF_WIN:
						prdata_q <= {rowEnd_q, rowStart_q,
							1'b0, colEnd_q, 1'b0, colStart_q};
					`ODCD_OFF_CFG0:
						prdata_q <= {cfg_q.muxRatio, cfg_q.offset,
							cfg_q.startLine, cfg_q.contrast};
					`ODCD_OFF_CFG1:
						prdata_q <= {20'h0_0000, state_q,
							cfg_q.segSwap, cfg_q.segHwRemap,
							cfg_q.segOddEven, cfg_q.locked,
							cfg_q.scanRev, cfg_q.displayOn,
							cfg_q.inverse, cfg_q.allOn,
							cfg_q.segRemap, cfg_q.portrait,
							cfg_q.vertMode};
					`ODCD_OFF_CFG2:
						prdata_q <= {11'h000, cfg_q.precharge,
							cfg_q.phase2, cfg_q.phase1,
							cfg_q.oscFreq, cfg_q.divide};
					`ODCD_OFF_GRAY:
						prdata_q <= {20'h0_0000, graySel_q,
							1'b0, gray_q[graySel_q]};
					default:
						prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// lock gate on bytes
	// only the lock command gets through while locked
	assign inByte = pwdata[7:0];
	assign take   = wrCmd & (~cfg_q.locked | (state_q == ODCD_PARAM) |
		(inByte == 8'hFD));
	assign need   = paramCount(cmd_q);

	// collect parameters first
	// a command fires only with its last byte, so nothing half applies
	assign fire = take & (((state_q == ODCD_IDLE) &&
		(paramCount(inByte) == 4'h0)) ||
		((state_q == ODCD_PARAM) && (cnt_q == need - 4'h1)));
	assign fCmd = (state_q == ODCD_IDLE) ? inByte : cmd_q;
	assign arg1 = (need == 4'h1) ? inByte : pbuf_q[0];
	assign arg2 = inByte;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ODCD_IDLE;
			cmd_q   <= 8'h00;
			cnt_q   <= 4'h0;
		end else if (take) begin
			unique case (state_q)
				ODCD_IDLE: begin
					cmd_q <= inByte;
					cnt_q <= 4'h0;
					if (paramCount(inByte) != 4'h0)
						state_q <= ODCD_PARAM;
				end
				ODCD_PARAM: begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == need - 4'h1)
						state_q <= ODCD_IDLE;
				end
			endcase
		end
	end

	// parameter bytes in arrival order
	always_ff @(posedge sys_clk) begin
		if (take && state_q == ODCD_PARAM)
			pbuf_q[cnt_q] <= inByte;
	end

	// display settings, each written by its own command
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q            <= '0;
			cfg_q.contrast   <= `ODCD_RST_CONTR;
			cfg_q.muxRatio   <= `ODCD_RST_MUX;
			cfg_q.precharge  <= `ODCD_RST_PRECH;
			cfg_q.divide     <= `ODCD_RST_DIV;
			cfg_q.oscFreq    <= `ODCD_RST_OSC;
			cfg_q.phase1     <= `ODCD_RST_PH1;
			cfg_q.phase2     <= `ODCD_RST_PH2;
			cfg_q.segOddEven <= 1'b1;
		end else if (fire) begin
			unique case (fCmd)
				8'h20: cfg_q.vertMode <= arg1[0];
				8'h25: cfg_q.portrait <= arg1[0];
				8'h81: cfg_q.contrast <= arg1;
				8'hA0, 8'hA1: cfg_q.segRemap <= fCmd[0];
				// start line, out of range ignored
				8'hA2: if (arg1 <= `ODCD_ROW_MAX)
					cfg_q.startLine <= arg1;
				8'hA4, 8'hA5: cfg_q.allOn <= fCmd[0];
				8'hA6, 8'hA7: cfg_q.inverse <= fCmd[0];
				8'hA8: if (arg1 >= `ODCD_MUX_MIN &&
					arg1 <= `ODCD_ROW_MAX)
					cfg_q.muxRatio <= arg1;
				8'hAE, 8'hAF: cfg_q.displayOn <= fCmd[0];
				8'hBC: cfg_q.precharge <= arg1[4:0];
				8'hC0, 8'hC8: cfg_q.scanRev <= fCmd[3];
				8'hD3: if (arg1 <= `ODCD_ROW_MAX)
					cfg_q.offset <= arg1;
				8'hD5: begin
					cfg_q.divide  <= arg1[3:0];
					cfg_q.oscFreq <= arg1[7:4];
				end
				8'hD9: begin
					if (arg1[3:0] != 4'h0)
						cfg_q.phase1 <= arg1[3:0];
					if (arg1[7:4] != 4'h0)
						cfg_q.phase2 <= arg1[7:4];
				end
				8'hDA: begin
					cfg_q.segOddEven <= arg1[`ODCD_ODDEVEN_BIT];
					cfg_q.segHwRemap <= arg1[`ODCD_HWREMAP_BIT];
					cfg_q.segSwap    <= arg1[`ODCD_SWAP_BIT];
				end
				8'hFD: cfg_q.locked <= arg1[`ODCD_LOCK_BIT];
				default: cfg_q.vertMode <= cfg_q.vertMode;
			endcase
		end
	end

	// gray widths; level 0 is only ever loaded with zero and stays zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 16; i++)
				gray_q[i] <= 7'(i * 4);
		end else if (fire && fCmd == 8'hBE) begin
			for (int i = 1; i < 15; i++)
				gray_q[i] <= pbuf_q[i-1][6:0];
			gray_q[15] <= arg2[6:0];
		end else if (fire && fCmd == 8'hBF) begin
			for (int i = 0; i < 16; i++)
				gray_q[i] <= 7'(i) * `ODCD_GRAY_STEP;
		end
	end

	// gray readback index, software chosen
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			graySel_q <= 4'h0;
		else if (acc && pwrite && paddr == `ODCD_OFF_GRAY)
			graySel_q <= pwdata[3:0];
	end

	// windows; out of range pairs are dropped whole
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			colStart_q <= 7'h00;
			colEnd_q   <= `ODCD_COL_MAX;
			rowStart_q <= 8'h00;
			rowEnd_q   <= `ODCD_ROW_MAX;
		end else if (fire) begin
			if (fCmd == 8'h21 && arg1 <= 8'(`ODCD_COL_MAX) &&
				arg2 <= 8'(`ODCD_COL_MAX)) begin
				colStart_q <= arg1[6:0];
				colEnd_q   <= arg2[6:0];
			end
			if (fCmd == 8'h22 && arg1 <= `ODCD_ROW_MAX &&
				arg2 <= `ODCD_ROW_MAX) begin
				rowStart_q <= arg1;
				rowEnd_q   <= arg2;
			end
		end
	end

	// address pointers: loaded by window commands, stepped by data
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			col_q <= 7'h00;
			row_q <= 8'h00;
		end else if (fire && fCmd == 8'h21 &&
			arg1 <= 8'(`ODCD_COL_MAX) && arg2 <= 8'(`ODCD_COL_MAX)) begin
			col_q <= arg1[6:0];
		end else if (fire && fCmd == 8'h22 &&
			arg1 <= `ODCD_ROW_MAX && arg2 <= `ODCD_ROW_MAX) begin
			row_q <= arg1;
		end else if (wrData && !cfg_q.locked) begin
			if (!cfg_q.vertMode) begin
				if (col_q == colEnd_q) begin
					col_q <= colStart_q;
					row_q <= (row_q == rowEnd_q) ? rowStart_q :
						row_q + 8'h01;
				end else begin
					col_q <= col_q + 7'h01;
				end
			end else begin
				if (row_q == rowEnd_q) begin
					row_q <= rowStart_q;
					col_q <= (col_q == colEnd_q) ? colStart_q :
						col_q + 7'h01;
				end else begin
					row_q <= row_q + 8'h01;
				end
			end
		end
	end

	// ram write strobe; remap is applied as the data goes in
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ramWr_q <= '0;
		end else begin
			ramWr_q.we       <= wrData & ~cfg_q.locked;
			ramWr_q.portrait <= cfg_q.portrait;
			ramWr_q.row      <= row_q;
			ramWr_q.data     <= pwdata[7:0];
			// mirror column for new data only
			ramWr_q.col      <= cfg_q.segRemap ?
				`ODCD_COL_MAX - col_q : col_q;
		end
	end

	// blank when off
	// shown level follows off, all-on and inverse in that priority
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			pix_q <= 4'h0;
		else
			pix_q <= showLevel(cfg_q, pixRaw);
	end

	assign pready   = pready_q;
	assign prdata   = prdata_q;
	assign pslverr  = pslverr_q;
	assign pixShown = pix_q;
	assign dispCfg  = cfg_q;
	assign ramWr    = ramWr_q;

endmodule

// *** odcd_sva.sv ***
// assertions on the ports of the display command decoder
`timescale 1ns/1ps
`include "odcd_cfg.svh"

module odcd_sva
	import odcd_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        arst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic [3:0]  pixRaw,
	input wire logic [3:0]  pixShown,
	input wire odcd_cfg_t   dispCfg,
	input wire odcd_ram_t   ramWr
);
	logic dataGo_q;
	logic cmdGo_q;
	wire logic acc = psel && penable && pready && pwrite;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// one wait state, then a single-cycle answer
	sequence accessWait;
		!pready ##1 pready ##1 !pready;
	endsequence

	// writes accepted at the previous edge; lock kills the data pulse
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			dataGo_q <= 1'b0;
			cmdGo_q <= 1'b0;
		end else begin
			dataGo_q <= acc && paddr == `ODCD_OFF_DATA && !dispCfg.locked;
			cmdGo_q <= acc && paddr == `ODCD_OFF_CMD;
		end
	end

	AST_APB_WAIT: assert property ($rose(penable) && psel |-> accessWait)
		else $error("answer not after one wait state");
	AST_APB_ERR: assert property (pready && (paddr[1:0] != 2'b00 ||
		paddr > 8'h1C) |-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	AST_DISP_OFF: assert property (
		!dispCfg.displayOn |=> pixShown == 4'h0)
		else $error("pixel shown while display off");
	AST_ALL_ON: assert property (
		dispCfg.displayOn && dispCfg.allOn |=> pixShown == 4'hF)
		else $error("all-on not brightest");
	AST_INVERSE: assert property (
		dispCfg.displayOn && !dispCfg.allOn && dispCfg.inverse
		|=> pixShown == 4'hF - $past(pixRaw))
		else $error("inverse level wrong");
	AST_FOLLOW: assert property (
		dispCfg.displayOn && !dispCfg.allOn && !dispCfg.inverse
		|=> pixShown == $past(pixRaw))
		else $error("pixel does not follow memory");
	AST_RAM_PULSE: assert property (ramWr.we == dataGo_q)
		else $error("memory write pulse wrong");
	AST_RAM_RANGE: assert property (ramWr.we |->
		ramWr.col <= `ODCD_COL_MAX && ramWr.row <= `ODCD_ROW_MAX)
		else $error("memory address out of range");
	AST_CFG_RANGE: assert property (
		dispCfg.muxRatio >= `ODCD_MUX_MIN &&
		dispCfg.startLine <= `ODCD_ROW_MAX &&
		dispCfg.offset <= `ODCD_ROW_MAX)
		else $error("setting out of range");
	AST_CFG_CAUSE: assert property (
		$past(arst_n) && $changed(dispCfg) |-> cmdGo_q)
		else $error("setting changed without command");
endmodule

bind odcd_top odcd_sva i_sva (
	.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .pixRaw(pixRaw),
	.pixShown(pixShown), .dispCfg(dispCfg), .ramWr(ramWr)
);

// *** odcd_host.sv ***
// host model: apb master sending command and data bytes
`timescale 1ns/1ps

module odcd_host (
	input  wire logic        sys_clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	// bus idle at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// setup, access held until pready, then release with scrambled lines
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= ~w;
		paddr <= ~a;
		pwdata <= ~d;
	endtask

	task automatic gray(input logic [7:0] k);
		logic [31:0] r;
		logic        e;
		xfer(1'b1, 8'h00, 32'h0000_00BE, r, e);
		for (int n = 1; n < 16; n++) begin
			xfer(1'b1, 8'h00, {24'h0, k * n[7:0]}, r, e);
		end
	endtask
endmodule

// *** odcd_tb.sv ***
// self-checking testbench for the display command decoder
`timescale 1ns/1ps

module tb
	import odcd_pkg::*;
;
	typedef struct packed {
		logic [7:0] c;
		logic [7:0] p;
		logic [7:0] a;
		logic [4:0] sh;
		logic [7:0] m;
		logic [7:0] x;
	} odcd_row_t;

	logic        sys_clk;
	logic        arst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [3:0]  pixRaw;
	logic [3:0]  pixShown;
	odcd_cfg_t   dispCfg;
	odcd_ram_t   ramWr;
	odcd_ram_t   seen;
	logic [31:0] r;
	logic        e;
	int          mismatches;
	int          checked;
	int          cycles;

	// command, parameter, register, shift, mask, expected field
	odcd_row_t rows [19] = '{
		'{8'hAF, 8'h00, 8'h14, 5'h05, 8'h01, 8'h01},
		'{8'h81, 8'h40, 8'h10, 5'h00, 8'hFF, 8'h40},
		'{8'hA2, 8'h9F, 8'h10, 5'h08, 8'hFF, 8'h9F},
		'{8'hA2, 8'hA0, 8'h10, 5'h08, 8'hFF, 8'h9F},
		'{8'hD3, 8'h9F, 8'h10, 5'h10, 8'hFF, 8'h9F},
		'{8'hA8, 8'h0F, 8'h10, 5'h18, 8'hFF, 8'h0F},
		'{8'hD5, 8'hA3, 8'h18, 5'h00, 8'hFF, 8'hA3},
		'{8'hD9, 8'h5C, 8'h18, 5'h08, 8'hFF, 8'h5C},
		'{8'hBC, 8'h15, 8'h18, 5'h10, 8'h1F, 8'h15},
		'{8'hDA, 8'h30, 8'h14, 5'h08, 8'h07, 8'h03},
		'{8'hDA, 8'h40, 8'h14, 5'h08, 8'h07, 8'h04},
		'{8'h20, 8'h01, 8'h14, 5'h00, 8'h01, 8'h01},
		'{8'h25, 8'h01, 8'h14, 5'h00, 8'h03, 8'h03},
		'{8'hA1, 8'h00, 8'h14, 5'h02, 8'h01, 8'h01},
		'{8'hA7, 8'h00, 8'h14, 5'h04, 8'h01, 8'h01},
		'{8'hA6, 8'h00, 8'h14, 5'h04, 8'h01, 8'h00},
		'{8'hA5, 8'h00, 8'h14, 5'h03, 8'h01, 8'h01},
		'{8'hA4, 8'h00, 8'h14, 5'h03, 8'h01, 8'h00},
		'{8'hC8, 8'h00, 8'h14, 5'h06, 8'h01, 8'h01}
	};

	odcd_top i_dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .pixRaw(pixRaw), .pixShown(pixShown),
		.dispCfg(dispCfg), .ramWr(ramWr)
	);

	odcd_host i_host (
		.sys_clk(sys_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr)
	);

	// clock, moving pixel level, last memory write, hang guard
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) pixRaw <= pixRaw + 4'h1;
	always @(posedge sys_clk) if (ramWr.we === 1'b1) seen <= ramWr;
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host.xfer(1'b1, a, {24'h0, d}, r, e);
	endtask

	// n bytes to the command port, most significant first
	task automatic cmds(input logic [63:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			wr(8'h00, v[8*i +: 8]);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [4:0] sh,
		input logic [31:0] m, input logic [31:0] x);
		i_host.xfer(1'b0, a, 32'h0000_0000, r, e);
		chk((r >> sh) & m, x);
	endtask

	task automatic conclude();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		arst_n = 1'b0;
		pixRaw = 4'h0;
		mismatches = 0;
		checked = 0;
		cycles = 0;
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(8'h10, 5'h00, 32'hFFFF_FFFF, 32'h9F00_007F);
		rd(8'h14, 5'h00, 32'h0000_0FFF, 32'h0000_0100);
		rd(8'h18, 5'h00, 32'hFFFF_FFFF, 32'h001E_7241);
		rd(8'h0C, 5'h00, 32'hFFFF_FFFF, 32'h9F00_4F00);
		wr(8'h1C, 8'h05);
		rd(8'h1C, 5'h00, 32'hFFFF_FFFF, 32'h0000_0514);
		$display("reset test done");
		foreach (rows[i]) begin
			wr(8'h00, rows[i].c);
			if (rows[i].p != 8'h00) wr(8'h00, rows[i].p);
			rd(rows[i].a, rows[i].sh, {24'h0, rows[i].m}, {24'h0, rows[i].x});
		end
		// shown level: all-on, inverse and off, one cycle behind
		wr(8'h00, 8'hA5);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({28'h0, pixShown}, 32'h0000_000F);
		wr(8'h00, 8'hA4);
		wr(8'h00, 8'hA7);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({28'h0, pixShown}, {28'h0, 4'hF - (pixRaw - 4'h1)});
		wr(8'h00, 8'hAE);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({28'h0, pixShown}, 32'h0000_0000);
		wr(8'h00, 8'hA6);
		wr(8'h00, 8'hAF);
		$display("command table done");
		// horizontal then vertical walk in a 2x2 window at the far corner
		cmds(64'h2000_214E_4F22_9E9F, 8);
		rd(8'h0C, 5'h00, 32'hFFFF_FFFF, 32'h9F9E_4F4E);
		repeat (3) wr(8'h04, 8'hA5);
		rd(8'h08, 5'h00, 32'hFFFF_FFFF, 32'h0000_9F4F);
		wr(8'h04, 8'hA5);
		rd(8'h08, 5'h00, 32'hFFFF_FFFF, 32'h0000_9E4E);
		chk({7'h00, seen}, {7'h00, 2'b11, 7'h00, 8'h9F, 8'hA5});
		cmds(64'h2001_214E_4F22_9E9F, 8);
		repeat (2) wr(8'h04, 8'h5A);
		rd(8'h08, 5'h00, 32'hFFFF_FFFF, 32'h0000_9E4F);
		repeat (2) wr(8'h04, 8'h5A);
		rd(8'h08, 5'h00, 32'hFFFF_FFFF, 32'h0000_9E4E);
		$display("pointer walk done");
		cmds(64'h0000_0000_FD04_8111, 4);
		wr(8'h04, 8'h00);
		rd(8'h14, 5'h07, 32'h0000_0001, 32'h0000_0001);
		rd(8'h10, 5'h00, 32'h0000_00FF, 32'h0000_0040);
		rd(8'h08, 5'h00, 32'hFFFF_FFFF, 32'h0000_9E4E);
		cmds(64'h0000_0000_FD00_8111, 4);
		rd(8'h10, 5'h00, 32'h0000_00FF, 32'h0000_0011);
		$display("lock test done");
		i_host.gray(8'h03);
		wr(8'h1C, 8'h0F);
		rd(8'h1C, 5'h00, 32'hFFFF_FFFF, 32'h0000_0F2D);
		wr(8'h1C, 8'h00);
		rd(8'h1C, 5'h00, 32'hFFFF_FFFF, 32'h0000_0000);
		cmds(64'h0000_0000_0000_00BF, 1);
		wr(8'h1C, 8'h0F);
		rd(8'h1C, 5'h00, 32'hFFFF_FFFF, 32'h0000_0F3C);
		$display("gray table done");
		// unmapped word and misaligned byte address are refused
		rd(8'h20, 5'h00, 32'hFFFF_FFFF, 32'h0000_0000);
		chk({31'h0, e}, 32'h0000_0001);
		wr(8'h02, 8'h11);
		chk({31'h0, e}, 32'h0000_0001);
		$display("bus error test done");
		conclude();
	end
endmodule
